// *** esm_cfg.svh ***
// constants of the exact-stop positioning monitor
`ifndef ESM_CFG_SVH
`define ESM_CFG_SVH

`define ESM_AXES 4
`define ESM_SPINDLE 3
// positioning alarm number 25080
`define ESM_ALARM_CODE 32'h000061f8
// timeout 5.0 s, held in milliseconds
`define ESM_POS_TIME_MS 32'h00001388
// interpolation cycle length in milliseconds
`define ESM_IPO_MS 32'h0000000c

`define ESM_OFS_CTRL 8'h00
`define ESM_OFS_TIME 8'h04
`define ESM_OFS_IPO 8'h08
`define ESM_OFS_STAT 8'h0c
`define ESM_OFS_CODE 8'h10
`define ESM_OFS_FLAGS 8'h14

`define ESM_CTRL_CLR 0
`define ESM_CTRL_APPLY 1
`define ESM_CTRL_FINE 2
`define ESM_ST_ALARM 0
`define ESM_ST_READY 1
`define ESM_ST_STOPPED 2
`define ESM_ST_DONE 3
`define ESM_ST_WAIT 8
`define ESM_FL_COARSE 0
`define ESM_FL_FINE 8

`define ESM_RESP_OK 2'h0
`define ESM_RESP_ERR 2'h2
`endif

// *** esm_pkg.sv ***
// types of the exact-stop positioning monitor
`include "esm_cfg.svh"
package esm_pkg;

  typedef enum logic {SUP_IDLE, SUP_WAIT} sup_e;

  typedef struct packed {
    logic ipo_end;
    logic ipo_active;
    logic in_coarse;
    logic in_fine;
    logic stopped;
  } axis_in_s;

  typedef struct packed {
    sup_e [`ESM_AXES-1:0] sup;
    logic [`ESM_AXES-1:0][31:0] elapsed;
    logic [31:0] time_pend;
    logic [31:0] time_act;
    logic [31:0] ipo_pend;
    logic [31:0] ipo_act;
    logic sel_fine;
    logic alarm;
    logic ready;
    logic stop;
    logic [`ESM_AXES-1:0] coarse;
    logic [`ESM_AXES-1:0] fine;
    logic all_stopped;
    logic blk_done;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

endpackage

// *** exact_stop_position_monitor.sv ***
// exact-stop positioning monitor with AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "esm_cfg.svh"
module exact_stop_position_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ipo_tick,
  input wire logic blk_start,
  input wire logic exact_stop,
  input wire logic spindle_pos,
  input wire logic ctrl_reset,
  input wire esm_pkg::axis_in_s [`ESM_AXES-1:0] axis_in,
  output logic [`ESM_AXES-1:0] coarse_reached,
  output logic [`ESM_AXES-1:0] fine_reached,
  output logic all_stopped,
  output logic ctrl_ready,
  output logic stop_axes,
  output logic pos_alarm,
  output logic blk_done,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  esm_pkg::state_s s;
  esm_pkg::state_s n;
  logic clr;
  logic apply;
  logic [`ESM_AXES-1:0] win_v;
  logic [`ESM_AXES-1:0] mon_v;
  logic [`ESM_AXES-1:0] wait_v;
  logic any_wait;
  logic all_in;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic known(input logic [7:0] a);
    return a == `ESM_OFS_CTRL || a == `ESM_OFS_TIME || a == `ESM_OFS_IPO ||
           a == `ESM_OFS_STAT || a == `ESM_OFS_CODE || a == `ESM_OFS_FLAGS;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input esm_pkg::state_s c,
                                          input logic [`ESM_AXES-1:0] wv);
    logic [31:0] w;
    w = '0;
    case (a)
      `ESM_OFS_CTRL: w[`ESM_CTRL_FINE] = c.sel_fine;
      `ESM_OFS_TIME: w = c.time_pend;
      `ESM_OFS_IPO: w = c.ipo_pend;
      `ESM_OFS_STAT: begin
        w[`ESM_ST_ALARM] = c.alarm;
        w[`ESM_ST_READY] = c.ready;
        w[`ESM_ST_STOPPED] = c.all_stopped;
        w[`ESM_ST_DONE] = c.blk_done;
        w[`ESM_ST_WAIT +: `ESM_AXES] = wv;
      end
      `ESM_OFS_CODE: w = `ESM_ALARM_CODE;
      `ESM_OFS_FLAGS: begin
        w[`ESM_FL_COARSE +: `ESM_AXES] = c.coarse;
        w[`ESM_FL_FINE +: `ESM_AXES] = c.fine;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  function automatic esm_pkg::state_s rst_state();
    esm_pkg::state_s r;
    r = '0;
    r.time_pend = `ESM_POS_TIME_MS;
    r.time_act = `ESM_POS_TIME_MS;
    r.ipo_pend = `ESM_IPO_MS;
    r.ipo_act = `ESM_IPO_MS;
    r.ready = 1'b1;
    r.awready = 1'b1;
    r.wready = 1'b1;
    r.arready = 1'b1;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-axis window and supervision scope

  always_comb begin
    for (int i = 0; i < `ESM_AXES; i++) begin
      win_v[i] = s.sel_fine ? axis_in[i].in_fine : axis_in[i].in_coarse;
      wait_v[i] = s.sup[i] == esm_pkg::SUP_WAIT;
      mon_v[i] = (i != `ESM_SPINDLE) || spindle_pos;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [32:0] sum;
    logic to_any;
    logic done_all;
    sum = '0;
    to_any = 1'b0;
    done_all = 1'b1;
    n = s;
    clr = 1'b0;
    apply = 1'b0;

    // write channel: address and data taken in either order
    if (awvalid && s.awready) begin
      n.aw_held = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_held = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = known(s.awaddr) ? `ESM_RESP_OK : `ESM_RESP_ERR;
      case (s.awaddr)
        `ESM_OFS_CTRL: begin
          if (s.wstrb[0]) begin
            clr = s.wdata[`ESM_CTRL_CLR];
            apply = s.wdata[`ESM_CTRL_APPLY];
            n.sel_fine = s.wdata[`ESM_CTRL_FINE];
          end
        end
        `ESM_OFS_TIME: n.time_pend = merge(s.time_pend, s.wdata, s.wstrb);
        `ESM_OFS_IPO: n.ipo_pend = merge(s.ipo_pend, s.wdata, s.wstrb);
        default: ;
      endcase
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;

    // read channel
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_word(araddr, s, wait_v);
      n.rresp = known(araddr) ? `ESM_RESP_OK : `ESM_RESP_ERR;
    end
    n.arready = !n.rvalid;

    // pending settings act only after apply
    if (apply) begin
      n.time_act = s.time_pend;
      n.ipo_act = s.ipo_pend;
    end

    for (int i = 0; i < `ESM_AXES; i++) begin
      sum = {1'b0, s.elapsed[i]} + {1'b0, s.ipo_act};
      if (blk_start) begin
        n.sup[i] = esm_pkg::SUP_IDLE;
        n.elapsed[i] = '0;
      end else begin
        unique case (s.sup[i])
          esm_pkg::SUP_IDLE: begin
            if (axis_in[i].ipo_end && exact_stop && mon_v[i] && !win_v[i]) begin
              n.sup[i] = esm_pkg::SUP_WAIT;
              n.elapsed[i] = '0;
            end
          end
          esm_pkg::SUP_WAIT: begin
            if (win_v[i]) begin
              n.sup[i] = esm_pkg::SUP_IDLE;
              n.elapsed[i] = '0;
            end else if (ipo_tick) begin
              if (sum >= {1'b0, s.time_act}) begin
                to_any = 1'b1;
                n.sup[i] = esm_pkg::SUP_IDLE;
                n.elapsed[i] = '0;
              end else begin
                n.elapsed[i] = sum[31:0];
              end
            end
          end
        endcase
      end
      // coarse flag, also when interpolator idle
      n.coarse[i] = axis_in[i].in_coarse || ctrl_reset || !axis_in[i].ipo_active;
      // fine flag, same terms on fine window
      n.fine[i] = axis_in[i].in_fine || ctrl_reset || !axis_in[i].ipo_active;
      done_all = done_all && (win_v[i] || !mon_v[i]);
    end

    n.blk_done = done_all;
    n.all_stopped = &{axis_in[3].stopped, axis_in[2].stopped,
                      axis_in[1].stopped, axis_in[0].stopped};
    // alarm wins over a same-cycle clear
    n.alarm = to_any || (s.alarm && !clr);
    n.ready = !n.alarm;
    n.stop = n.alarm;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= rst_state();
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign coarse_reached = s.coarse;
  assign fine_reached = s.fine;
  assign all_stopped = s.all_stopped;
  assign ctrl_ready = s.ready;
  assign stop_axes = s.stop;
  assign pos_alarm = s.alarm;
  assign blk_done = s.blk_done;
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // plain helper nets so that the checks below sample signals, not expressions
  assign any_wait = |wait_v;
  assign all_in = &(win_v | ~mon_v);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_alarm_ready: assert property (pos_alarm |-> !ctrl_ready && stop_axes)
    else $error("ready high or axes running under alarm");

  a_alarm_cause: assert property ($rose(pos_alarm) |-> $past(any_wait) && $past(ipo_tick))
    else $error("alarm without expired supervision");

  a_spindle_free: assert property (
    !wait_v[`ESM_SPINDLE] && !spindle_pos && !rst |=> !wait_v[`ESM_SPINDLE])
    else $error("spindle supervised outside position mode");

  a_block_clear: assert property (blk_start |=> wait_v == '0)
    else $error("supervision survived block start");

  a_apply_only: assert property (!apply |=> $stable(s.time_act))
    else $error("timeout changed without apply");

  a_block_hold: assert property (blk_done |-> $past(all_in))
    else $error("block done outside window");

  a_stop_flag: assert property (
    (axis_in[0].stopped && axis_in[1].stopped && axis_in[2].stopped && axis_in[3].stopped)
    |=> all_stopped)
    else $error("all stopped flag missing");

  for (genvar g = 0; g < `ESM_AXES; g++) begin : g_chk
    a_timer_start: assert property (
      !wait_v[g] && axis_in[g].ipo_end && exact_stop && mon_v[g] && !win_v[g] && !blk_start
      |=> wait_v[g])
      else $error("timer not started at interpolator end");

    a_coarse_set: assert property (axis_in[g].in_coarse |=> coarse_reached[g])
      else $error("coarse flag missing in window");

    a_coarse_drop: assert property (
      !axis_in[g].in_coarse && axis_in[g].ipo_active && !ctrl_reset |=> !coarse_reached[g])
      else $error("coarse flag held outside window");

    a_fine_drop: assert property (
      !axis_in[g].in_fine && axis_in[g].ipo_active && !ctrl_reset |=> !fine_reached[g])
      else $error("fine flag held outside window");
  end

  c_alarm: cover property ($rose(pos_alarm));
  c_done: cover property ($rose(blk_done));
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);

endmodule // exact_stop_position_monitor

// *** plc_model.sv ***
// machine-logic controller model sampling the status flags
`timescale 1ns/1ps
`include "esm_cfg.svh"
module plc_model (
  input wire logic ref_clk,
  input wire logic [`ESM_AXES-1:0] coarse_reached,
  input wire logic [`ESM_AXES-1:0] fine_reached,
  input wire logic all_stopped,
  output logic [8:0] seen
);
  // levels, no edges
  // edge detection would miss a flag that is already high at power-up
  always_ff @(posedge ref_clk) begin
    seen <= {all_stopped, fine_reached, coarse_reached};
  end
endmodule // plc_model

// *** exact_stop_position_monitor_tb.sv ***
// self-checking bench of the exact-stop positioning monitor
`timescale 1ns/1ps
`include "esm_cfg.svh"
module exact_stop_position_monitor_tb;
  logic ref_clk, rst, ipo_tick, blk_start, exact_stop, spindle_pos, ctrl_reset;
  esm_pkg::axis_in_s [`ESM_AXES-1:0] ax;
  logic [`ESM_AXES-1:0] coarse_reached, fine_reached;
  logic all_stopped, ctrl_ready, stop_axes, pos_alarm, blk_done;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  logic [8:0] seen;
  int fails = 0;
  int samples_checked = 0;

  exact_stop_position_monitor i_dut (.ref_clk(ref_clk), .rst(rst), .ipo_tick(ipo_tick), .blk_start(blk_start),
    .exact_stop(exact_stop), .spindle_pos(spindle_pos), .ctrl_reset(ctrl_reset), .axis_in(ax),
    .coarse_reached(coarse_reached), .fine_reached(fine_reached), .all_stopped(all_stopped),
    .ctrl_ready(ctrl_ready), .stop_axes(stop_axes), .pos_alarm(pos_alarm), .blk_done(blk_done),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  plc_model i_plc (.ref_clk(ref_clk), .coarse_reached(coarse_reached), .fine_reached(fine_reached),
    .all_stopped(all_stopped), .seen(seen));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge ref_clk);
    awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // track acceptance locally: the valid flags only change after the edge
    while (!aw_done || !w_done) begin
      @(posedge ref_clk);
      if (awready) aw_done = 1'b1;
      if (wready) w_done = 1'b1;
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end
    while (!bvalid) @(posedge ref_clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge ref_clk);
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask

  task automatic tick();
    @(posedge ref_clk) ipo_tick <= 1'b1;
    @(posedge ref_clk) ipo_tick <= 1'b0;
  endtask

  // mode 1: window reached after first tick, mode 2: new block after first tick
  task automatic sup(input int i, input int n, input int mode, input logic e);
    // fresh block so no earlier wait survives
    @(posedge ref_clk) blk_start <= 1'b1;
    @(posedge ref_clk) begin
      blk_start <= 1'b0;
      ax[i].ipo_end <= 1'b1;
    end
    @(posedge ref_clk) ax[i].ipo_end <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(blk_done, 1'b0);
    for (int k = 0; k < n; k++) begin
      tick();
      if (k == 0 && mode == 1) ax[i].in_coarse <= 1'b1;
      if (k == 0 && mode == 2) begin
        @(posedge ref_clk) blk_start <= 1'b1;
        @(posedge ref_clk) blk_start <= 1'b0;
      end
    end
    repeat (3) @(posedge ref_clk);
    chk(pos_alarm, e);
    chk({stop_axes, ctrl_ready}, {e, !e});
    rd(`ESM_OFS_STAT);
    chk(d[0], e);
    wr(`ESM_OFS_CTRL, 32'h00000001);
    ax[i].in_coarse <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(pos_alarm, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #300us;
    fails++;
    final_report();
  end

  initial begin
    rst = 1'b1; ipo_tick = 0; blk_start = 0; exact_stop = 1; spindle_pos = 0; ctrl_reset = 0;
    ax = '0;
    for (int i = 0; i < `ESM_AXES; i++) ax[i].ipo_active = 1'b1;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    chk({ctrl_ready, pos_alarm}, 2'h2);
    rd(`ESM_OFS_CODE);
    chk(d, `ESM_ALARM_CODE);
    rd(`ESM_OFS_TIME);
    chk(d, `ESM_POS_TIME_MS);
    rd(8'h20);
    chk(r, `ESM_RESP_ERR);
    wr(8'h24, 32'h00000001);
    chk(r, `ESM_RESP_ERR);
    // window flags: axis0 coarse only, axis1 both, axis2 interpolator idle
    // fine never set without coarse
    ax[0].in_coarse <= 1; ax[1].in_coarse <= 1; ax[1].in_fine <= 1; ax[2].ipo_active <= 0;
    repeat (3) @(posedge ref_clk);
    chk(seen[7:0], 8'h67);
    rd(`ESM_OFS_FLAGS);
    chk(d, 32'h00000607);
    ax[0].in_coarse <= 0; ax[1].in_fine <= 0;
    repeat (3) @(posedge ref_clk);
    chk(seen[7:0], 8'h46);
    ctrl_reset <= 1;
    for (int i = 0; i < `ESM_AXES; i++) ax[i].stopped <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(seen, 9'h1ff);
    ax <= '0;
    ctrl_reset <= 0;
    for (int i = 0; i < `ESM_AXES; i++) ax[i].ipo_active <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(seen, 9'h000);
    // fine window selected: coarse alone must not complete the block
    // coarse raised first, then fine
    wr(`ESM_OFS_CTRL, 32'h00000004);
    for (int i = 0; i < `ESM_AXES; i++) ax[i].in_coarse <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(blk_done, 1'b0);
    for (int i = 0; i < `ESM_AXES; i++) ax[i].in_fine <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(blk_done, 1'b1);
    rd(`ESM_OFS_CTRL);
    chk(d, 32'h00000004);
    wr(`ESM_OFS_CTRL, 32'h00000000);
    for (int i = 0; i < `ESM_AXES; i++) ax[i].in_coarse <= 1'b0;
    for (int i = 0; i < `ESM_AXES; i++) ax[i].in_fine <= 1'b0;
    // pending timeout of 24 ms, 12 ms cycle, not yet applied
    wr(`ESM_OFS_TIME, 32'h00000018);
    wr(`ESM_OFS_IPO, 32'h0000000c);
    sup(0, 3, 0, 1'b0);
    wr(`ESM_OFS_CTRL, 32'h00000002);
    sup(0, 1, 0, 1'b0);
    sup(1, 2, 0, 1'b1);
    sup(0, 3, 1, 1'b0);
    sup(2, 3, 2, 1'b0);
    // block without exact stop is not supervised
    exact_stop <= 1'b0;
    sup(1, 2, 0, 1'b0);
    exact_stop <= 1'b1;
    sup(3, 3, 0, 1'b0);
    spindle_pos <= 1;
    sup(3, 2, 0, 1'b1);
    final_report();
  end
endmodule // exact_stop_position_monitor_tb
